// File: shared/pd_hold_pkg.sv
// constants and carrier types for the pin power-down hold block
// assumes a single 10 MHz clock domain
`default_nettype none
package pd_hold_pkg;
    localparam int clk_period_ns = 100;
    localparam int setup_before_ns = 10;
    localparam int stop_sample_ns = 5;
    localparam int recovery_us = 2;
    localparam int ns_per_us = 1000;
    // longest times round down, never below one cycle
    localparam int stop_sample_cyc_raw = stop_sample_ns / clk_period_ns;
    localparam int stop_sample_cycles = (stop_sample_cyc_raw < 1) ? 1 : stop_sample_cyc_raw;
    localparam int recovery_cyc_raw = (recovery_us * ns_per_us) / clk_period_ns;
    localparam int recovery_cycles = (recovery_cyc_raw < 1) ? 1 : recovery_cyc_raw;
    // the pin is seen one edge late and inputs return one edge after recovery, so both come off the budget
    localparam int recovery_lag = 2;
    localparam logic [cnt_w-1:0] recovery_start = cnt_w'(recovery_cycles - recovery_lag);
    localparam int cnt_w = 8;
    localparam logic [cnt_w-1:0] cnt_zero = 8'h00;
    localparam logic [cnt_w-1:0] cnt_one = 8'h01;
    localparam logic [cnt_w-1:0] recovery_load = cnt_w'(recovery_cycles);
    localparam int io_w = 8;
    localparam logic [io_w-1:0] io_reset = 8'h00;

    typedef enum logic [2:0] {
        st_run = 3'b001,
        st_sleep = 3'b010,
        st_recover = 3'b100
    } pd_state_t;

    typedef struct packed {
        logic [io_w-1:0] data;
        logic [io_w-1:0] oe;
    } pin_bus_t;
endpackage
`default_nettype wire

// File: rtl/pin_power_down_hold.sv
// pin-controlled power-down hold: freezes user logic and outputs, turns on pin keepers
// assumes all inputs synchronous to clk_in; the user core sits behind this block
// Operation
// - sleep pin acts as power-down only when the enable setting is on.
// - while sleep pin high, hold every internal state and output value.
// - outputs in high-impedance at power-down onset stay high-impedance throughout.
// - during power-down, block all inputs except the sleep pin.
// - pin hold latches stay active during power-down so pins never float.
// - in power-down use, the sleep pin's array input is hidden from user logic.
// - stop sampling inputs no later than 5 ns after sleep pin rises.
// - resume inputs, enables, clocks and valid outputs within 2 us after fall.
`default_nettype none
module pin_power_down_hold
    import pd_hold_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic pd_enable_in,
    input wire logic sleep_request_pin_in,
    input wire pin_bus_t pins_in,
    input wire pin_bus_t core_out_in,
    output logic sleep_request_array_out,
    output pin_bus_t core_pins_out,
    output pin_bus_t pads_out,
    output logic core_clk_en_out,
    output logic keeper_en_out,
    output logic sleeping_out
);
    pd_state_t state;
    logic pd_enable;
    logic enable_caught;
    logic [cnt_w-1:0] recover_cnt;
    logic sleep_req;

    // strap captured once after reset release, then frozen
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pd_enable <= 1'b0;
            enable_caught <= 1'b0;
        end else if (!enable_caught) begin
            pd_enable <= pd_enable_in;
            enable_caught <= 1'b1;
        end
    end

    a_caught_once: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        enable_caught |=> enable_caught
    ) else $error("strap capture reopened");
    a_enable_static: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        $past(enable_caught) |-> $stable(pd_enable)
    ) else $error("enable changed");

    assign sleep_req = pd_enable && enable_caught && sleep_request_pin_in;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= st_run;
            recover_cnt <= cnt_zero;
        end else begin
            unique case (state)
                st_run: begin
                    if (sleep_req) begin
                        state <= st_sleep;
                    end
                end
                st_sleep: begin
                    if (!sleep_req) begin
                        state <= st_recover;
                        recover_cnt <= recovery_start;
                    end
                end
                st_recover: begin
                    if (sleep_req) begin
                        state <= st_sleep;
                    end else if (recover_cnt <= cnt_one) begin
                        state <= st_run;
                        recover_cnt <= cnt_zero;
                    end else begin
                        recover_cnt <= recover_cnt - cnt_one;
                    end
                end
                default: begin
                    state <= st_run;
                end
            endcase
        end
    end

    localparam int recover_max = recovery_cycles;

    a_run_when_off: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !pd_enable |-> (state == st_run)
    ) else $error("power-down entered while disabled");
    a_sleep_entry: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_run) && sleep_req |=> (state == st_sleep)
    ) else $error("sleep request not taken");
    a_resleep: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_recover) && sleep_req |=> (state == st_sleep)
    ) else $error("sleep request lost in recovery");
    a_recover_count: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_recover) |-> (recover_cnt != cnt_zero) && (recover_cnt <= recovery_start)
    ) else $error("recovery count out of range");
    // counted from the edge that sees the pin low, so the pin-to-edge lag falls outside this bound
    a_recover_bound: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_sleep) && !sleep_req |-> ##[1:recover_max] (core_clk_en_out || sleep_req)
    ) else $error("recovery too long");
    a_no_edge_recover: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        $past(state) == st_recover |-> !core_clk_en_out
    ) else $error("edge during recovery");

    // gating decided combinationally from the pin so sampling stops in the same edge
    logic run_now;
    assign run_now = (state == st_run) && !sleep_req;

    // inputs pass only while running; otherwise the last sampled value is held
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_pins_out <= '{data: io_reset, oe: io_reset};
        end else if (run_now) begin
            core_pins_out <= pins_in;
        end
    end

    a_inputs_blocked: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_sleep) && $past(state == st_sleep) |-> $stable(core_pins_out)
    ) else $error("input leaked");
    a_core_frozen_recover: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_recover) |-> $stable(core_pins_out)
    ) else $error("input leaked in recovery");
    a_pins_follow: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        run_now |=> (core_pins_out == $past(pins_in))
    ) else $error("inputs not passed while running");

    // sleep pin array input is hidden when used for power-down
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleep_request_array_out <= 1'b0;
        end else if (!pd_enable) begin
            sleep_request_array_out <= sleep_request_pin_in;
        end else begin
            sleep_request_array_out <= 1'b0;
        end
    end

    a_array_hidden: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        pd_enable |=> !sleep_request_array_out
    ) else $error("sleep pin seen by array");
    a_array_follows: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !pd_enable |=> (sleep_request_array_out == $past(sleep_request_pin_in))
    ) else $error("sleep pin lost its ordinary role");

    // outputs and enables freeze, so high-impedance pads stay released
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pads_out <= '{data: io_reset, oe: io_reset};
        end else if (run_now) begin
            pads_out <= core_out_in;
        end
    end

    a_hold_outputs: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !$past(run_now) |-> $stable(pads_out)
    ) else $error("pads changed in power-down");
    a_hiz_kept: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_sleep) |-> (pads_out.oe == $past(pads_out.oe))
    ) else $error("oe changed asleep");
    a_oe_frozen_recover: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_recover) |-> $stable(pads_out.oe)
    ) else $error("oe changed in recovery");
    a_pads_follow: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        run_now |=> (pads_out == $past(core_out_in))
    ) else $error("outputs not passed while running");

    // core registers only advance on enabled edges
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_clk_en_out <= 1'b0;
            keeper_en_out <= 1'b0;
            sleeping_out <= 1'b0;
        end else begin
            core_clk_en_out <= run_now;
            keeper_en_out <= !run_now;
            sleeping_out <= (state != st_run) || sleep_req;
        end
    end

    a_stop_sample: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        sleep_req |=> !core_clk_en_out
    ) else $error("clock enable after sleep rise");
    a_stop_keeper: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        sleep_req |=> keeper_en_out
    ) else $error("keeper late after sleep rise");
    a_keeper_on: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state == st_sleep) |-> keeper_en_out
    ) else $error("keeper off in power-down");
    a_keeper_release: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        run_now |=> !keeper_en_out
    ) else $error("keeper left on while running");
    a_clk_en_run: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        run_now |=> core_clk_en_out
    ) else $error("clock enable missing while running");
    a_sleep_flag: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state != st_run) |=> sleeping_out
    ) else $error("sleeping flag low in power-down");
endmodule
`default_nettype wire

// File: tb/sleep_driver.sv
// model of the system logic that drives the sleep request pin
// assumes want_sleep_in changes just after a rising edge of clk_in
`default_nettype none
module sleep_driver (
    input wire logic clk_in,
    input wire logic want_sleep_in,
    output logic sleep_request_pin_out,
    output logic inputs_free_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial sleep_request_pin_out = 1'b0;
    initial inputs_free_out = 1'b0;
    // pin rises a full cycle after the request, so inputs sat still long before it
    always @(posedge clk_in) sleep_request_pin_out <= want_sleep_in;
    // inputs are let go only once the edge that saw the pin high has passed
    always @(posedge clk_in) inputs_free_out <= sleep_request_pin_out;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// bench for the power-down hold block: random pin traffic, sleep entry, hold and exit
// assumes the design package and the sleep driver model are compiled first
`default_nettype none
module testbench import pd_hold_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, nrst_in = 0, en = 0, want = 0, pin, free, arr, clk_en, keep, slp;
    pin_bus_t pins = '0, core = '0, cpo, pads, a, b;
    int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'hb5c7, k;
    sleep_driver sleep_driver_i (.clk_in(clk_in), .want_sleep_in(want), .sleep_request_pin_out(pin),
        .inputs_free_out(free));
    pin_power_down_hold pin_power_down_hold_i (.clk_in(clk_in), .nrst_in(nrst_in), .pd_enable_in(en),
        .sleep_request_pin_in(pin), .pins_in(pins), .core_out_in(core), .sleep_request_array_out(arr),
        .core_pins_out(cpo), .pads_out(pads), .core_clk_en_out(clk_en), .keeper_en_out(keep), .sleeping_out(slp));
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc == 1000) begin error_cnt++; close_out(); end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic exp_array(input logic e, input logic p);
        return e ? 1'b0 : p;
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset(input logic e);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        en <= e;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    // random traffic while running: both paths copy their input one edge later
    task automatic traffic(input int n);
        pin_bus_t lc, lp;
        repeat (n) begin
            @(posedge clk_in);
            lc = core;
            lp = pins;
            core <= pin_bus_t'($random(seed));
            pins <= pin_bus_t'($random(seed));
            #1;
            check(pads, lc);
            check(cpo, lp);
            check(clk_en, 1'b1);
        end
    endtask
    initial begin
        do_reset(1'b0);
        @(posedge clk_in);
        want <= 1'b1;
        repeat (3) @(posedge clk_in);
        en <= 1'b1;
        traffic(6);
        check({slp, keep}, 2'b00);
        check(arr, exp_array(1'b0, pin));
        @(posedge clk_in);
        want <= 1'b0;
        do_reset(1'b1);
        traffic(8);
        @(posedge clk_in);
        want <= 1'b1;
        a = core;
        b = pins;
        k = 0;
        while (free !== 1'b1 && k < 10) begin
            @(posedge clk_in);
            k++;
        end
        repeat (8) begin
            @(posedge clk_in);
            core <= pin_bus_t'($random(seed));
            pins <= pin_bus_t'($random(seed));
            en <= 1'($random(seed));
            #1;
            check(pads, a);
            check(pads.oe, a.oe);
            check(cpo, b);
            check({keep, clk_en, slp}, 3'b101);
            check(arr, exp_array(1'b1, pin));
        end
        // pin returns mid-recovery: the hold must outlast a whole recovery time
        @(posedge clk_in);
        want <= 1'b0;
        repeat (5) @(posedge clk_in);
        want <= 1'b1;
        repeat (recovery_cycles + 5) @(posedge clk_in);
        #1;
        check(pads, a);
        check(cpo, b);
        check({keep, clk_en, slp}, 3'b101);
        @(posedge clk_in);
        want <= 1'b0;
        k = 0;
        while (clk_en !== 1'b1 && k < 40) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        // the driver lowers the pin one edge after want, so the budget starts one edge late
        check(16'(k <= recovery_cycles + 1), 16'h0001);
        traffic(8);
        close_out();
    end
endmodule
`default_nettype wire
